// ### pkg/mpp_pkg.sv
// Constants and types for the Manchester programming port
package mpp_pkg;

  // ***************
  // Timing
  // ***************
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned PROG_LOW_US = 84;
  localparam int unsigned OUT_EN_US = 125;
  localparam int unsigned EE_WR_US = 24_000;
  localparam int unsigned UNLOCK_US = 50_000;
  localparam int unsigned PROG_LOW_CYC = PROG_LOW_US * CLK_MHZ;
  localparam int unsigned OUT_EN_CYC = OUT_EN_US * CLK_MHZ;
  localparam int unsigned EE_WR_CYC = EE_WR_US * CLK_MHZ;
  localparam int unsigned UNLOCK_CYC = UNLOCK_US * CLK_MHZ;

  // ***************
  // Frame layout
  // ***************
  localparam logic [6:0] WR_BITS = 7'h2c;
  localparam logic [6:0] RD_BITS = 7'h0c;
  localparam logic [6:0] ACK_HALVES = 7'h44;
  localparam logic [6:0] RW_IDX = 7'h02;
  localparam logic [6:0] CRC_BITS = 7'h03;
  localparam logic [2:0] CRC_POLY = 3'h3;
  localparam logic [5:0] ACCESS_ADDR = 6'h36;
  localparam logic [31:0] ACCESS_CODE = 32'hc4136737;
  localparam logic [5:0] EE_TOP = 6'h20;
  localparam logic [5:0] LOCK_ADDR = 6'h1f;
  localparam int LOCK_POS = 25;

  // ***************
  // Register map
  // ***************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HALF = 8'h08;

  typedef enum logic [9:0] {
    PH_RUN = 10'h001,
    PH_ARM = 10'h002,
    PH_IDLE = 10'h004,
    PH_MEAS = 10'h008,
    PH_RX = 10'h010,
    PH_EEWR = 10'h020,
    PH_EEACK = 10'h040,
    PH_ACKW = 10'h080,
    PH_TX = 10'h100,
    PH_RESUME = 10'h200
  } mpp_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mpp_apb_req_t;

  typedef struct packed {
    mpp_phase_t ph;
    logic [1:0] sup_s;
    logic [1:0] pen_s;
    logic [1:0] pin_s;
    logic pin_d;
    logic init;
    logic perm;
    logic unlocked;
    logic win_open;
    logic [20:0] win;
    logic [15:0] cnt;
    logic [15:0] half;
    logic [6:0] nb;
    logic rw;
    logic [2:0] crc;
    logic [43:0] sh;
    logic [19:0] tmr;
    logic [33:0] tx_sh;
    logic sel;
    logic tx;
    logic aout;
    logic dis;
    logic crc_err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mpp_state_t;

  localparam mpp_state_t ST_RST = '{
    ph: PH_RUN, init: 1'b1, win_open: 1'b1, aout: 1'b1, default: '0};

endpackage : mpp_pkg

// ### rtl/mpp_device.sv
// Manchester programming port of the sensor, with APB status and control
`timescale 1ns/1ns

module mpp_device
  import mpp_pkg::*;
#(
  parameter int unsigned EE_WR_CYCLES = EE_WR_CYC,
  parameter int unsigned UNLOCK_CYCLES = UNLOCK_CYC,
  parameter bit HAS_PROG_PIN = 1'b1
)(
  input wire logic mclk,
  input wire logic srst,
  input wire mpp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_prog_high,
  input wire logic program_enable_pin,
  input wire logic sensor_output_pin_in,
  output logic sensor_output_pin_out,
  output logic sensor_output_pin_oe,
  output logic analog_output_enable
);

  // ***************
  // Storage
  // ***************
  logic [31:0] mem [64];
  logic nv_lock = 1'b0;
  mpp_state_t st;
  mpp_state_t next_st;
  logic mem_we;
  logic [5:0] mem_wa;
  logic [31:0] mem_wd;
  logic lock_set;

  function automatic logic [5:0] ecc_of(input logic [25:0] d);
    logic [5:0] e;
    e = '0;
    for (int j = 0; j < 26; j++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        if ((((j + 1) >> i) % 2) == 1)
        begin
          e[i] = e[i] ^ d[j];
        end
      end
      e[5] = e[5] ^ d[j];
    end
    return e;
  endfunction : ecc_of

  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
    return {c[1:0], 1'b0} ^ ((c[2] ^ b) ? CRC_POLY : 3'h0);
  endfunction : crc_step

  // ***************
  // Next state
  // ***************
  always_comb
  begin
    logic prog;
    logic edge_r;
    logic edge_f;
    logic bv;
    logic rwe;
    logic ok;
    logic tick;
    logic [6:0] flen;
    logic [6:0] nbn;
    logic [43:0] shn;
    logic [31:0] rd;
    logic [31:0] wdat;
    logic [5:0] wadr;
    logic [16:0] lim;
    prog = 1'b0;
    edge_r = 1'b0;
    edge_f = 1'b0;
    bv = 1'b0;
    rwe = 1'b0;
    ok = 1'b0;
    tick = 1'b0;
    flen = WR_BITS;
    nbn = 7'h00;
    shn = '0;
    rd = '0;
    wdat = '0;
    wadr = '0;
    lim = '0;
    next_st = st;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    lock_set = 1'b0;

    next_st.sup_s = {st.sup_s[0], supply_prog_high};
    next_st.pen_s = {st.pen_s[0], program_enable_pin};
    next_st.pin_s = {st.pin_s[0], sensor_output_pin_in};
    next_st.pin_d = st.pin_s[1];
    edge_r = st.pin_s[1] & ~st.pin_d;
    edge_f = ~st.pin_s[1] & st.pin_d;
    prog = st.sup_s[1] | (HAS_PROG_PIN & st.pen_s[1]);
    tick = (st.cnt + 16'h0001) >= st.half;
    nbn = st.nb + 7'h01;

    // Lock bit sampled once after each reset
    next_st.init = 1'b0;
    if (st.init)
    begin
      next_st.perm = nv_lock;
    end
    if (st.win_open)
    begin
      next_st.win = st.win + 21'h000001;
      if (st.win == 21'(UNLOCK_CYCLES - 1))
      begin
        next_st.win_open = 1'b0;
      end
    end

    case (st.ph)
      PH_RUN:
      begin
        next_st.sel = 1'b0;
        if (prog)
        begin
          next_st.ph = PH_ARM;
          next_st.tmr = '0;
        end
      end
      PH_ARM:
      begin
        // Pin ignored until the controller has had time to pull it low
        next_st.tmr = st.tmr + 20'h00001;
        if (st.tmr == 20'(PROG_LOW_CYC - 1))
        begin
          next_st.ph = PH_IDLE;
        end
      end
      PH_IDLE:
      begin
        if (edge_r)
        begin
          // First rise is the mid edge of the first sync zero
          next_st.ph = PH_MEAS;
          next_st.cnt = '0;
          next_st.nb = 7'h01;
          next_st.sh = '0;
          next_st.crc = '0;
          next_st.rw = 1'b0;
        end
      end
      PH_MEAS:
      begin
        next_st.cnt = st.cnt + 16'h0001;
        if (edge_f)
        begin
          next_st.half = st.cnt;
          next_st.ph = PH_RX;
        end
        else if (&st.cnt)
        begin
          next_st.ph = PH_IDLE;
        end
      end
      PH_RX:
      begin
        next_st.cnt = st.cnt + 16'h0001;
        lim = {1'b0, st.half} + {st.half, 1'b0};
        if ((edge_r | edge_f) && (st.cnt >= st.half + (st.half >> 1)))
        begin
          bv = edge_f;
          shn = {st.sh[42:0], bv};
          rwe = (st.nb == RW_IDX) ? bv : st.rw;
          flen = rwe ? RD_BITS : WR_BITS;
          next_st.sh = shn;
          next_st.nb = nbn;
          next_st.cnt = '0;
          next_st.rw = rwe;
          if ((st.nb >= RW_IDX) && (st.nb < flen - CRC_BITS))
          begin
            next_st.crc = crc_step(st.crc, bv);
          end
          if (nbn == flen)
          begin
            next_st.ph = PH_IDLE;
            ok = (st.crc == shn[2:0]) & ~(rwe ? shn[10] : shn[42]);
            next_st.crc_err = ~ok;
            if (ok && !st.perm)
            begin
              if (rwe)
              begin
                rd = mem[shn[8:3]];
                next_st.tx_sh = {8'h00, rd[25:0]};
                if (ecc_of(rd[25:0]) != rd[31:26])
                begin
                  next_st.tx_sh[27:26] = 2'b11;
                end
                next_st.ph = PH_ACKW;
                next_st.cnt = '0;
                next_st.nb = '0;
              end
              else
              begin
                wadr = shn[40:35];
                wdat = shn[34:3];
                if (wadr == ACCESS_ADDR)
                begin
                  if ((wdat == ACCESS_CODE) && st.win_open)
                  begin
                    next_st.unlocked = 1'b1;
                  end
                end
                else if (st.unlocked)
                begin
                  mem_we = 1'b1;
                  mem_wa = wadr;
                  mem_wd = {ecc_of(wdat[25:0]), wdat[25:0]};
                  if (wadr < EE_TOP)
                  begin
                    next_st.ph = PH_EEWR;
                    next_st.tmr = '0;
                    lock_set = (wadr == LOCK_ADDR) & wdat[LOCK_POS];
                  end
                end
              end
            end
          end
        end
        else if ({1'b0, st.cnt} >= lim)
        begin
          next_st.ph = PH_IDLE;
        end
      end
      PH_EEWR:
      begin
        next_st.tmr = st.tmr + 20'h00001;
        if (st.tmr == 20'(EE_WR_CYCLES - 1))
        begin
          next_st.ph = PH_EEACK;
          next_st.cnt = '0;
          next_st.nb = '0;
          next_st.sel = 1'b1;
          next_st.tx = 1'b1;
        end
      end
      PH_EEACK:
      begin
        // One bit high, one bit low, then release
        next_st.cnt = st.cnt + 16'h0001;
        if (tick)
        begin
          next_st.cnt = '0;
          next_st.nb = nbn;
          next_st.tx = (nbn < 7'h02);
          if (nbn == 7'h04)
          begin
            next_st.sel = 1'b0;
            next_st.tx = 1'b0;
            next_st.ph = PH_IDLE;
          end
        end
      end
      PH_ACKW:
      begin
        // Two bit times for the controller to let go of the pin
        next_st.cnt = st.cnt + 16'h0001;
        if (tick)
        begin
          next_st.cnt = '0;
          next_st.nb = nbn;
          if (nbn == 7'h04)
          begin
            next_st.ph = PH_TX;
            next_st.nb = '0;
            next_st.sel = 1'b1;
            next_st.tx = st.tx_sh[33];
          end
        end
      end
      PH_TX:
      begin
        // Pin input ignored while replying
        next_st.cnt = st.cnt + 16'h0001;
        if (tick)
        begin
          next_st.cnt = '0;
          next_st.nb = nbn;
          if (!st.nb[0])
          begin
            next_st.tx = ~st.tx_sh[33];
          end
          else
          begin
            next_st.tx_sh = {st.tx_sh[32:0], 1'b0};
            next_st.tx = st.tx_sh[32];
          end
          if (nbn == ACK_HALVES)
          begin
            next_st.sel = 1'b0;
            next_st.tx = 1'b0;
            next_st.ph = PH_IDLE;
            next_st.nb = '0;
          end
        end
      end
      PH_RESUME:
      begin
        next_st.tmr = st.tmr + 20'h00001;
        if (prog)
        begin
          next_st.ph = PH_ARM;
          next_st.tmr = '0;
        end
        else if (st.tmr == 20'(OUT_EN_CYC - 1))
        begin
          next_st.ph = PH_RUN;
        end
      end
      default:
      begin
        next_st.ph = PH_RUN;
        next_st.sel = 1'b0;
      end
    endcase

    if (!prog && (st.ph != PH_RUN) && (st.ph != PH_RESUME))
    begin
      next_st.ph = PH_RESUME;
      next_st.tmr = '0;
      next_st.sel = 1'b0;
      next_st.tx = 1'b0;
    end

    // ***************
    // APB slave
    // ***************
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !st.pready)
    begin
      next_st.pready = 1'b1;
      case (apb_req.paddr)
        REG_CTRL: next_st.prdata = {31'h0, st.dis};
        REG_STATUS: next_st.prdata = {27'h0, st.crc_err, (st.ph == PH_EEWR),
                                      st.perm, st.unlocked, prog};
        REG_HALF: next_st.prdata = {16'h0, st.half};
        default:
        begin
          next_st.prdata = '0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_req.psel && apb_req.penable && st.pready && apb_req.pwrite
        && (apb_req.paddr == REG_CTRL))
    begin
      next_st.dis = apb_req.pwdata[0];
    end

    // Analog only when serial drive is off and not disabled
    next_st.aout = ~next_st.sel & ~next_st.dis & (next_st.ph == PH_RUN);
  end

  // ***************
  // Registers
  // ***************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st <= ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Nonvolatile words and lock bit survive reset; lock never clears
  always_ff @(posedge mclk)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
    if (lock_set)
    begin
      nv_lock <= 1'b1;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign sensor_output_pin_out = st.tx;
  assign sensor_output_pin_oe = st.sel;
  assign analog_output_enable = st.aout;

endmodule : mpp_device

// ### sim/mpp_device_sva.sv
// Checker for the programming port pins and APB answers
`timescale 1ns/1ns
module mpp_device_sva
  import mpp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire mpp_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_prog_high,
  input wire logic program_enable_pin,
  input wire logic sensor_output_pin_in,
  input wire logic sensor_output_pin_out,
  input wire logic sensor_output_pin_oe,
  input wire logic analog_output_enable
);
  logic dis;
  logic prog;
  logic wr_ctrl;
  assign prog = supply_prog_high | program_enable_pin;
  assign wr_ctrl = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  // Copy of the output disable bit
  always_ff @(posedge mclk)
    if (srst)
      dis <= 1'b0;
    else if (wr_ctrl && apb_req.paddr == REG_CTRL)
      dis <= apb_req.pwdata[0];
  // Cycles since program mode was left
  logic prog_d;
  logic res_on;
  logic [12:0] res_cnt;
  localparam logic [12:0] RES_LO = 13'h0c1c;
  localparam logic [12:0] RES_HI = 13'h0c44;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prog_d <= 1'b0;
      res_on <= 1'b0;
      res_cnt <= '0;
    end
    else
    begin
      prog_d <= prog;
      if (prog)
      begin
        res_on <= 1'b0;
      end
      else if (prog_d)
      begin
        res_on <= 1'b1;
        res_cnt <= '0;
      end
      else if (res_on && (res_cnt != RES_HI))
      begin
        res_cnt <= res_cnt + 13'h0001;
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  property p_wait; apb_req.psel && apb_req.penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_oe; sensor_output_pin_oe |-> !analog_output_enable; endproperty
  a_oe: assert property (p_oe) else $error("analog while driving");
  property p_dis; dis && $past(dis) && $past(dis, 2) |-> !analog_output_enable; endproperty
  a_dis: assert property (p_dis) else $error("analog while disabled");
  property p_entry; $rose(prog) |-> ##[1:5] !analog_output_enable && !sensor_output_pin_oe; endproperty
  a_entry: assert property (p_entry) else $error("pin not released");
  property p_exit; $fell(prog) |-> ##[0:4] !sensor_output_pin_oe; endproperty
  a_exit: assert property (p_exit) else $error("pin held after exit");
  property p_resume_lo; res_on && !prog && !dis && (res_cnt < RES_LO) |->
    !analog_output_enable; endproperty
  a_resume_lo: assert property (p_resume_lo) else $error("analog back too early");
  property p_resume_hi; res_on && !prog && !dis && (res_cnt == RES_HI) |->
    analog_output_enable; endproperty
  a_resume_hi: assert property (p_resume_hi) else $error("analog back too late");
  property p_ack; $rose(sensor_output_pin_oe) && sensor_output_pin_out |=>
    sensor_output_pin_out[*8]; endproperty
  a_ack: assert property (p_ack) else $error("ack high too short");
  property p_sync; $rose(sensor_output_pin_oe) && !sensor_output_pin_out |=>
    !sensor_output_pin_out[*8]; endproperty
  a_sync: assert property (p_sync) else $error("reply sync wrong");
endmodule : mpp_device_sva

bind mpp_device mpp_device_sva i_mpp_device_sva (.mclk(mclk), .srst(srst), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_prog_high(supply_prog_high),
  .program_enable_pin(program_enable_pin), .sensor_output_pin_in(sensor_output_pin_in),
  .sensor_output_pin_out(sensor_output_pin_out), .sensor_output_pin_oe(sensor_output_pin_oe),
  .analog_output_enable(analog_output_enable));

// ### sim/mpp_ctrl_model.sv
// Programming controller on the shared sensor pin
`timescale 1ns/1ns
module mpp_ctrl_model
#(
  parameter int HALF = 125
)(
  input wire logic mclk,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin
);
  logic drv = 1'b0;
  logic lvl = 1'b0;
  // Pull-down holds a released wire low
  assign pin = dev_oe ? dev_out : (drv & lvl);
  task automatic send(input logic [43:0] f, input int n);
    drv <= 1'b1;
    lvl <= 1'b0;
    repeat (2 * HALF) @(posedge mclk);
    for (int i = n - 1; i >= 0; i--)
    begin
      lvl <= f[i];
      repeat (HALF) @(posedge mclk);
      lvl <= ~f[i];
      repeat (HALF) @(posedge mclk);
    end
    drv <= 1'b0;
  endtask : send
  // Decode a reply from its mid-bit edges
  task automatic recv(output logic [33:0] d, output bit ok);
    int k;
    logic p;
    ok = 1'b1;
    k = 0;
    while (dev_oe !== 1'b1 && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    for (int i = 33; i >= 0; i--)
    begin
      p = pin;
      while (pin === p && k < 50000)
      begin
        @(posedge mclk);
        k++;
      end
      d[i] = ~pin;
      repeat (HALF + HALF / 2) @(posedge mclk);
    end
    ok = k < 2000 + 34 * 4 * HALF;
  endtask : recv
endmodule : mpp_ctrl_model

// ### sim/tb_manchester_program_port.sv
// Self-checking bench of the programming port
`timescale 1ns/1ns
module tb_manchester_program_port
  import mpp_pkg::*;
;
  localparam int HALF = 125;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic pen = 1'b0;
  logic sup = 1'b0;
  mpp_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  logic dout;
  logic doe;
  logic aen;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rnd = 32'h21;
  logic [25:0] mem[int];
  bit unl = 1'b0;
  bit lck = 1'b0;
  logic [31:0] r;
  logic e;
  logic [33:0] d;
  bit ok;
  always #20 mclk = ~mclk;
  mpp_device #(.EE_WR_CYCLES(200), .UNLOCK_CYCLES(20000)) i_mpp_device (.mclk(mclk),
    .srst(srst), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_prog_high(sup), .program_enable_pin(pen), .sensor_output_pin_in(pin),
    .sensor_output_pin_out(dout), .sensor_output_pin_oe(doe), .analog_output_enable(aen));
  mpp_ctrl_model #(.HALF(HALF)) i_mpp_ctrl_model (.mclk(mclk), .dev_oe(doe), .dev_out(dout),
    .pin(pin));
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [33:0] s, input logic [33:0] x);
    tests_run++;
    if (s !== x)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask : chk
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [43:0] mk(input logic rw, input logic [5:0] a, input logic [31:0] v);
    logic [38:0] x;
    logic [2:0] c;
    x = {rw, a, v};
    c = 3'h0;
    for (int i = 38; i > (rw ? 31 : -1); i--)
      c = {c[1:0], 1'b0} ^ ((c[2] ^ x[i]) ? 3'h3 : 3'h0);
    mk = rw ? {34'h0, x[38:32], c} : {2'h0, x, c};
  endfunction : mk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: v};
    @(posedge mclk);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk(0, 1);
      test_done;
    end
  endtask : apb
  task automatic wait_oe(input logic lv, input int lim, output bit f);
    for (int k = 0; doe !== lv && k < lim; k++)
      @(posedge mclk);
    f = doe === lv;
  endtask : wait_oe
  task automatic sts(input logic [4:0] m, input logic [4:0] x);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r[4:0] & m, x);
  endtask : sts
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    bit f;
    i_mpp_ctrl_model.send(mk(1'b0, a, v), 44);
    wait_oe(1'b1, 1000, f);
    chk(f, unl && a < EE_TOP);
    if (f)
    begin
      chk(dout, 1'b1);
      wait_oe(1'b0, 600, f);
      chk(f, 1'b1);
    end
    if (unl)
      mem[a] = v[25:0];
    if (a == ACCESS_ADDR && v == ACCESS_CODE)
      unl = 1'b1;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    i_mpp_ctrl_model.send(mk(1'b1, a, 32'h0), 12);
    if (lck)
    begin
      wait_oe(1'b1, 1000, ok);
      chk(ok, 1'b0);
    end
    else
    begin
      i_mpp_ctrl_model.recv(d, ok);
      chk(ok, 1'b1);
      chk(d, {8'h0, mem[a]});
      if (!ok)
        test_done;
    end
  endtask : rd
  initial
  begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    chk({doe, aen}, 2'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    for (int v = 1; v >= 0; v--)
    begin
      apb(1'b1, REG_CTRL, v);
      repeat (3) @(posedge mclk);
      chk(aen, !v);
    end
    pen <= 1'b1;
    repeat (2300) @(posedge mclk);
    chk({doe, aen}, 2'h0);
    sts(5'h03, 5'h01);
    wr(ACCESS_ADDR, ACCESS_CODE);
    sts(5'h02, 5'h02);
    apb(1'b0, REG_HALF, 32'h0);
    // Count starts the cycle after the detected rise
    chk(r, HALF - 1);
    rnd = lfsr(rnd);
    wr(6'h20, rnd);
    rd(6'h20);
    rnd = lfsr(rnd);
    wr(LOCK_ADDR, rnd | (32'h1 << LOCK_POS));
    rd(LOCK_ADDR);
    i_mpp_ctrl_model.send(mk(1'b1, 6'h05, 32'h0) ^ 44'h1, 12);
    wait_oe(1'b1, 1000, ok);
    chk(ok, 1'b0);
    sts(5'h14, 5'h10);
    pen <= 1'b0;
    srst <= 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    unl = 1'b0;
    lck = 1'b1;
    sup <= 1'b1;
    repeat (2300) @(posedge mclk);
    sts(5'h07, 5'h05);
    wr(6'h05, lfsr(rnd));
    rd(LOCK_ADDR);
    sup <= 1'b0;
    repeat (3300) @(posedge mclk);
    chk({doe, aen}, 2'h1);
    test_done;
  end
endmodule : tb_manchester_program_port
